// ---- dv/ptm_pin_model.sv ----
// far-side pin driver: external clock, capture input and subclock pins
`timescale 1ns/100ps

module ptm_pin_model (
  input  wire logic ref_clk,
  output logic      external_clock_pin,
  output logic      capture_input_pin,
  output logic      sub_clock_pin
);
  // pins idle low, so every pulse gives exactly one rise and one fall
  initial
  begin
    external_clock_pin = 1'b0;
    capture_input_pin = 1'b0;
    sub_clock_pin = 1'b0;
  end

  // 0 clock pin, 1 capture pin, 2 subclock pin
  task automatic drive(input int idx, input logic val);
    case (idx)
      0: external_clock_pin <= val;
      1: capture_input_pin <= val;
      default: sub_clock_pin <= val;
    endcase
  endtask

  // edges four system cycles apart so the synchroniser sees each one
  task automatic pulse(input int idx, input int n);
    repeat (n)
    begin
      drive(idx, 1'b1);
      repeat (4) @(posedge ref_clk);
      drive(idx, 1'b0);
      repeat (4) @(posedge ref_clk);
    end
  endtask
endmodule

// ---- dv/tb.sv ----
// self-checking bench of the periodic timer over apb and its pins
`timescale 1ns/100ps
`include "ptm_cfg.svh"

module tb;
  import ptm_pkg::*;
  localparam int         W       = 10;
  localparam logic [7:0] HI_MASK = (W == 16) ? 8'hff : 8'h03;
  logic        ref_clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        timer_output_pin;
  logic        timer_output_en;
  logic        ext_pin;
  logic        cap_pin;
  logic        sub_pin;
  logic [31:0] q;
  logic [31:0] a;
  logic [31:0] b;
  logic [31:0] c;
  logic        err;
  logic        act;
  logic [7:0]  d;
  logic [11:0] ra [5];
  logic [7:0]  rm [5];
  int          fail_count;
  int          tests_run;
  int          seed;
  int          n;

  ptm_top #(.WIDTH(W)) uut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_clock_pin(ext_pin), .capture_input_pin(cap_pin),
    .sub_clock_pin(sub_pin), .timer_output_pin(timer_output_pin),
    .timer_output_en(timer_output_en));

  ptm_pin_model pm (.ref_clk(ref_clk), .external_clock_pin(ext_pin),
    .capture_input_pin(cap_pin), .sub_clock_pin(sub_pin));

  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_rng(input string nm, input int e, input logic [31:0] g, input int tol);
    tests_run++;
    if ($isunknown(g) || g > e + tol || g + tol < e)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  // one apb transfer, entered right after a rising edge
  task automatic apb(input logic w, input logic [11:0] ad, input logic [7:0] dt);
    int t;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= {24'h0, dt};
    @(posedge ref_clk);
    penable <= 1'b1;
    t = 0;
    do
    begin
      @(posedge ref_clk);
      t++;
    end
    while (pready !== 1'b1);
    // zero wait states: the answer stands in the first access cycle
    chk("bus wait states", 1, t);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd_cnt(output logic [31:0] v);
    apb(1'b0, `PTM_OFS_COUNT_LO, 8'h00);
    v = {24'h0, q[7:0]};
    apb(1'b0, `PTM_OFS_COUNT_HI, 8'h00);
    v[15:8] = q[7:0];
  endtask

  task automatic start(input logic [7:0] c1, input logic [2:0] sel);
    apb(1'b1, `PTM_OFS_CTRL0, 8'h00);
    apb(1'b1, `PTM_OFS_CTRL1, c1);
    apb(1'b1, `PTM_OFS_STATUS, 8'h03);
    apb(1'b1, `PTM_OFS_CTRL0, {1'b0, sel, 4'h8});
  endtask

  function automatic int div_of(input int s);
    case (s)
      0: return 4;
      1: return 1;
      2: return 16;
      default: return 64;
    endcase
  endfunction

  function automatic logic lvl(input logic [1:0] f, input logic i);
    case (f)
      2'b00: return i;
      2'b01: return 1'b0;
      2'b10: return 1'b1;
      default: return ~i;
    endcase
  endfunction

  // active cycles in a window of whole pwm periods; a p match clears, so pe+1 ticks
  function automatic int pwm_on(input int len, input int du, input int pe);
    return (len / (pe + 1)) * du;
  endfunction

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge ref_clk);
    fail_count++;
    $display("CHECK FAILED watchdog expected finish seen timeout");
    complete_run;
  end

  initial
  begin
    seed = 37682;
    fail_count = 0;
    tests_run = 0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ra = '{`PTM_OFS_CTRL0, `PTM_OFS_CTRL1, `PTM_OFS_DUTY_HI, `PTM_OFS_PERIOD_LO,
           `PTM_OFS_PERIOD_HI};
    rm = '{8'hf8, 8'hff, HI_MASK, 8'hff, HI_MASK};
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    for (int k = 0; k < 9; k++)
    begin
      apb(1'b0, 12'(4 * k), 8'h00);
      chk("reset value", 0, q);
    end
    // random readback, timer kept off
    for (int i = 0; i < 20; i++)
    begin
      d = 8'($random(seed));
      if (i % 5 == 0)
        d[3] = 1'b0;
      apb(1'b1, ra[i % 5], d);
      apb(1'b0, ra[i % 5], 8'h00);
      chk("register readback", {24'h0, d & rm[i % 5]}, q);
    end
    apb(1'b0, 12'h030, 8'h00);
    chk("unmapped error", 1, err);
    chk("unmapped data", 0, q);
    apb(1'b1, `PTM_OFS_CTRL1, 8'h00);
    apb(1'b1, `PTM_OFS_PERIOD_LO, 8'h00);
    apb(1'b1, `PTM_OFS_PERIOD_HI, 8'h00);
    apb(1'b1, `PTM_OFS_DUTY_HI, 8'h00);
    for (int s = 0; s < 4; s++)
    begin
      start(8'h00, 3'(s));
      repeat (64) @(posedge ref_clk);
      apb(1'b1, `PTM_OFS_CTRL0, 8'h00);
      rd_cnt(c);
      chk_rng("count rate", 67 / div_of(s), c, 3);
    end
    for (int s = 4; s < 8; s++)
    begin
      n = ($unsigned($random(seed)) % 8) + 1;
      start(8'h00, 3'(s));
      pm.pulse((s < 6) ? 2 : 0, n);
      repeat (8) @(posedge ref_clk);
      apb(1'b1, `PTM_OFS_CTRL0, 8'h00);
      rd_cnt(c);
      chk("edge count", n, c);
    end
    start(8'h00, PTM_CLK_SYS);
    repeat (20) @(posedge ref_clk);
    apb(1'b1, `PTM_OFS_CTRL0, 8'h10);
    rd_cnt(a);
    repeat (10) @(posedge ref_clk);
    rd_cnt(b);
    chk("frozen count", a, b);
    apb(1'b1, `PTM_OFS_CTRL0, 8'h18);
    rd_cnt(c);
    chk_rng("restart count", 4, c, 4);
    repeat (30) @(posedge ref_clk);
    apb(1'b1, `PTM_OFS_CTRL0, 8'h98);
    rd_cnt(a);
    repeat (10) @(posedge ref_clk);
    rd_cnt(b);
    chk("paused count", a, b);
    apb(1'b1, `PTM_OFS_CTRL0, 8'h18);
    repeat (10) @(posedge ref_clk);
    rd_cnt(c);
    chk_rng("resumed count", a + 14, c, 5);
    apb(1'b1, `PTM_OFS_DUTY_LO, 8'h08);
    for (int k = 0; k < 16; k++)
    begin
      start({PTM_MODE_COMPARE, 2'(k >> 2), 2'(k), 2'b00}, PTM_CLK_SYS);
      repeat (3) @(posedge ref_clk);
      chk("initial level", k[1] ^ k[0], timer_output_pin);
      chk("output enable", 1, timer_output_en);
      repeat (20) @(posedge ref_clk);
      chk("match level", lvl(2'(k >> 2), k[1]) ^ k[0], timer_output_pin);
    end
    for (int m = 1; m < 4; m += 2)
    begin
      start({2'(m), 6'($random(seed))}, PTM_CLK_SYS);
      repeat (3) @(posedge ref_clk);
      chk("pin undriven", 0, {timer_output_en, timer_output_pin});
    end
    apb(1'b1, `PTM_OFS_DUTY_LO, 8'h03);
    apb(1'b1, `PTM_OFS_PERIOD_LO, 8'h05);
    for (int s = 0; s < 2; s++)
    begin
      start(8'(s), PTM_CLK_SYS);
      repeat (40) @(posedge ref_clk);
      apb(1'b1, `PTM_OFS_CTRL0, 8'h00);
      apb(1'b0, `PTM_OFS_STATUS, 8'h00);
      chk("match flags", s ? 1 : 3, q);
      rd_cnt(c);
      chk("count bounded", 1, c <= (s ? 3 : 5));
      apb(1'b1, `PTM_OFS_PERIOD_LO, 8'h02);
    end
    apb(1'b1, `PTM_OFS_DUTY_LO, 8'h04);
    apb(1'b1, `PTM_OFS_PERIOD_LO, 8'h10);
    for (int f = 0; f < 3; f++)
    begin
      d = 8'($random(seed));
      act = d[1] ^ d[0];
      start({PTM_MODE_PWM, 2'(f), d[1:0], 2'b00}, PTM_CLK_SYS);
      repeat (4) @(posedge ref_clk);
      n = 0;
      repeat (68)
      begin
        @(posedge ref_clk);
        if (timer_output_pin === act)
          n++;
      end
      chk_rng("pwm active cycles", (f == 0) ? 0 : (f == 1) ? 68 : pwm_on(68, 4, 16), n, 2);
    end
    apb(1'b1, `PTM_OFS_DUTY_LO, 8'h14);
    start({PTM_MODE_PWM, 4'b1110, 2'b00}, PTM_CLK_SYS);
    repeat (5) @(posedge ref_clk);
    chk("pulse active", 1, timer_output_pin);
    repeat (40) @(posedge ref_clk);
    chk("pulse ended", 0, timer_output_pin);
    apb(1'b0, `PTM_OFS_CTRL0, 8'h00);
    chk("on bit after pulse", 8'h10, q);
    apb(1'b1, `PTM_OFS_PERIOD_LO, 8'h00);
    for (int k = 0; k < 8; k++)
    begin
      // keep comparator a out of reach so only captures raise flag a
      apb(1'b1, `PTM_OFS_DUTY_LO, 8'hff);
      start({PTM_MODE_CAPTURE, 2'(k), 2'b00, k[2], 1'b0}, PTM_CLK_SYS);
      for (int p = 0; p < 2; p++)
      begin
        pm.drive(1 - p, 1'b1);
        repeat (8) @(posedge ref_clk);
        apb(1'b0, `PTM_OFS_STATUS, 8'h00);
        chk("capture on rise", (k[2] == p) && (k[0] == 0), q[0]);
        apb(1'b1, `PTM_OFS_STATUS, 8'h03);
        pm.drive(1 - p, 1'b0);
        repeat (8) @(posedge ref_clk);
        apb(1'b0, `PTM_OFS_STATUS, 8'h00);
        chk("capture on fall", (k[2] == p) && (k[1] ^ k[0]), q[0]);
        apb(1'b1, `PTM_OFS_STATUS, 8'h03);
      end
    end
    complete_run;
  end
endmodule

// ---- hdl/ptm_cfg.svh ----
// register offsets, field positions, reset values and divider counts of the periodic timer
`ifndef PTM_CFG_SVH
`define PTM_CFG_SVH
`define PTM_OFS_CTRL0      12'h000
`define PTM_OFS_CTRL1      12'h004
`define PTM_OFS_DUTY_LO    12'h008
`define PTM_OFS_DUTY_HI    12'h00c
`define PTM_OFS_PERIOD_LO  12'h010
`define PTM_OFS_PERIOD_HI  12'h014
`define PTM_OFS_COUNT_LO   12'h018
`define PTM_OFS_COUNT_HI   12'h01c
`define PTM_OFS_STATUS     12'h020
`define PTM_C0_PAUSE       7
`define PTM_C0_CLK_HI      6
`define PTM_C0_CLK_LO      4
`define PTM_C0_ON          3
`define PTM_C1_MODE_HI     7
`define PTM_C1_MODE_LO     6
`define PTM_C1_PIN_HI      5
`define PTM_C1_PIN_LO      4
`define PTM_C1_INIT        3
`define PTM_C1_INV         2
`define PTM_C1_CAPSRC      1
`define PTM_C1_CLRSEL      0
`define PTM_ST_FLAG_A      0
`define PTM_ST_FLAG_P      1
`define PTM_CTRL_RESET     8'h00
`define PTM_CMP_RESET      16'h0000
`define PTM_DIV_SYS        6'h03
`define PTM_DIV_H16        6'h0f
`define PTM_DIV_H64        6'h3f
`endif

// ---- hdl/ptm_pkg.sv ----
// types of the periodic timer
package ptm_pkg;
  typedef enum logic [1:0] {
    PTM_MODE_COMPARE = 2'b00,
    PTM_MODE_CAPTURE = 2'b01,
    PTM_MODE_PWM     = 2'b10,
    PTM_MODE_TIMER   = 2'b11
  } ptm_mode_t;
  typedef enum logic [2:0] {
    PTM_CLK_SYS_DIV4 = 3'b000,
    PTM_CLK_SYS      = 3'b001,
    PTM_CLK_H_DIV16  = 3'b010,
    PTM_CLK_H_DIV64  = 3'b011,
    PTM_CLK_SUB_A    = 3'b100,
    PTM_CLK_SUB_B    = 3'b101,
    PTM_CLK_EXT_RISE = 3'b110,
    PTM_CLK_EXT_FALL = 3'b111
  } ptm_clk_sel_t;
endpackage

// ---- hdl/ptm_top.sv ----
// periodic timer counter, comparators, pin logic and apb register file
`timescale 1ns/100ps
`include "ptm_cfg.svh"

module ptm_top #(
  parameter int WIDTH = 10
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        external_clock_pin,
  input  wire logic        capture_input_pin,
  input  wire logic        sub_clock_pin,
  output logic             timer_output_pin,
  output logic             timer_output_en
);
  import ptm_pkg::*;

  initial
  begin
    if (WIDTH != 10 && WIDTH != 16)
      $error("ptm_top: WIDTH must be 10 or 16");
  end

  localparam logic [WIDTH-1:0] CNT_ONE = {{(WIDTH-1){1'b0}}, 1'b1};

  logic [7:0]       ctrl0_reg;
  logic [7:0]       ctrl1_reg;
  logic [WIDTH-1:0] duty_reg;
  logic [WIDTH-1:0] period_reg;
  logic [WIDTH-1:0] count_reg;
  logic             flag_a_reg;
  logic             flag_p_reg;
  logic             on_prev_reg;
  logic [5:0]       presc_reg;
  logic [2:0]       sync1_reg;
  logic [2:0]       sync2_reg;
  logic [2:0]       prev_reg;
  logic             level_reg;
  logic [31:0]      rdata_next;
  logic             err_next;

  function automatic logic [7:0] hi_byte(input logic [WIDTH-1:0] v);
    logic [15:0] w;
    w = 16'(v);
    return w[15:8];
  endfunction

  function automatic logic [WIDTH-1:0] set_hi(input logic [WIDTH-1:0] v,
                                              input logic [7:0] b);
    logic [WIDTH-1:0] r;
    r = v;
    r[WIDTH-1:8] = b[WIDTH-9:0];
    return r;
  endfunction

  wire logic       count_pause   = ctrl0_reg[`PTM_C0_PAUSE];
  wire logic       counter_on    = ctrl0_reg[`PTM_C0_ON];
  wire logic [2:0] clk_field     = ctrl0_reg[`PTM_C0_CLK_HI:`PTM_C0_CLK_LO];
  wire logic [1:0] mode_field    = ctrl1_reg[`PTM_C1_MODE_HI:`PTM_C1_MODE_LO];
  wire logic [1:0] pin_function_sel = ctrl1_reg[`PTM_C1_PIN_HI:`PTM_C1_PIN_LO];
  wire logic       output_initial_level = ctrl1_reg[`PTM_C1_INIT];
  wire logic       output_invert = ctrl1_reg[`PTM_C1_INV];
  wire logic       capture_source_sel = ctrl1_reg[`PTM_C1_CAPSRC];
  wire logic       clear_source_sel = ctrl1_reg[`PTM_C1_CLRSEL];
  ptm_mode_t       operating_mode_sel;
  ptm_clk_sel_t    clock_source_sel;
  assign operating_mode_sel = ptm_mode_t'(mode_field);
  assign clock_source_sel   = ptm_clk_sel_t'(clk_field);

  wire logic apb_setup = psel && !penable;
  wire logic apb_write = psel && penable && pready && pwrite && !pslverr;

  // pin synchronisers: 0 external clock, 1 capture, 2 subclock
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      prev_reg  <= 3'h0;
    end
    else
    begin
      sync1_reg <= {sub_clock_pin, capture_input_pin, external_clock_pin};
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  wire logic [2:0] rise = sync2_reg & ~prev_reg;
  wire logic [2:0] fall = ~sync2_reg & prev_reg;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      presc_reg <= 6'h00;
    else
      presc_reg <= presc_reg + 6'h01;
  end

  logic tick;
  always_comb
  begin
    case (clock_source_sel)
      PTM_CLK_SYS_DIV4: tick = presc_reg[1:0] == `PTM_DIV_SYS;
      PTM_CLK_SYS:      tick = 1'b1;
      PTM_CLK_H_DIV16:  tick = presc_reg[3:0] == `PTM_DIV_H16;
      PTM_CLK_H_DIV64:  tick = presc_reg == `PTM_DIV_H64;
      PTM_CLK_SUB_A,
      PTM_CLK_SUB_B:    tick = rise[2];
      PTM_CLK_EXT_RISE: tick = rise[0];
      PTM_CLK_EXT_FALL: tick = fall[0];
      default:          tick = 1'b0;
    endcase
  end

  wire logic on_rise  = counter_on && !on_prev_reg;
  wire logic run_tick = counter_on && !count_pause && tick && !on_rise;
  wire logic match_a  = run_tick && count_reg == duty_reg;
  wire logic match_p  = run_tick && period_reg != '0 && count_reg == period_reg;
  wire logic is_cmp   = operating_mode_sel == PTM_MODE_COMPARE ||
                        operating_mode_sel == PTM_MODE_TIMER;
  wire logic is_pulse = operating_mode_sel == PTM_MODE_PWM && pin_function_sel == 2'b11;

  logic clear_now;
  always_comb
  begin
    if (is_cmp)
      clear_now = clear_source_sel ? match_a : match_p;
    else if (is_pulse)
      clear_now = 1'b0;
    else
      clear_now = match_p;
  end

  // capture edge from the chosen pin
  wire logic cap_rise = capture_source_sel ? rise[0] : rise[1];
  wire logic cap_fall = capture_source_sel ? fall[0] : fall[1];
  logic cap_edge;
  always_comb
  begin
    case (pin_function_sel)
      2'b00:   cap_edge = cap_rise;
      2'b01:   cap_edge = cap_fall;
      2'b10:   cap_edge = cap_rise || cap_fall;
      default: cap_edge = 1'b0;
    endcase
  end
  wire logic capture = operating_mode_sel == PTM_MODE_CAPTURE && counter_on && cap_edge;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      on_prev_reg <= 1'b0;
    else
      on_prev_reg <= counter_on;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      count_reg <= '0;
    else if (on_rise)
      count_reg <= '0;
    else if (run_tick)
      count_reg <= clear_now ? '0 : count_reg + CNT_ONE;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      ctrl0_reg <= `PTM_CTRL_RESET;
    else if (apb_write && paddr == `PTM_OFS_CTRL0)
      ctrl0_reg <= {pwdata[7:3], 3'b000};
    else if (is_pulse && match_a)
      ctrl0_reg[`PTM_C0_ON] <= 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      ctrl1_reg <= `PTM_CTRL_RESET;
    else if (apb_write && paddr == `PTM_OFS_CTRL1)
      ctrl1_reg <= pwdata[7:0];
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      duty_reg <= WIDTH'(`PTM_CMP_RESET);
    else if (capture)
      duty_reg <= count_reg;
    else if (apb_write && paddr == `PTM_OFS_DUTY_LO)
      duty_reg[7:0] <= pwdata[7:0];
    else if (apb_write && paddr == `PTM_OFS_DUTY_HI)
      duty_reg <= set_hi(duty_reg, pwdata[7:0]);
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      period_reg <= WIDTH'(`PTM_CMP_RESET);
    else if (apb_write && paddr == `PTM_OFS_PERIOD_LO)
      period_reg[7:0] <= pwdata[7:0];
    else if (apb_write && paddr == `PTM_OFS_PERIOD_HI)
      period_reg <= set_hi(period_reg, pwdata[7:0]);
  end

  // sticky flags, write one to clear, a new event wins
  wire logic clr_a = apb_write && paddr == `PTM_OFS_STATUS && pwdata[`PTM_ST_FLAG_A];
  wire logic clr_p = apb_write && paddr == `PTM_OFS_STATUS && pwdata[`PTM_ST_FLAG_P];
  wire logic set_a = match_a || capture;
  wire logic set_p = match_p && !(is_cmp && clear_source_sel);
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      flag_a_reg <= 1'b0;
      flag_p_reg <= 1'b0;
    end
    else
    begin
      flag_a_reg <= set_a || (flag_a_reg && !clr_a);
      flag_p_reg <= set_p || (flag_p_reg && !clr_p);
    end
  end

  // internal output level before the invert stage
  wire logic duty_full = period_reg != '0 && duty_reg >= period_reg;
  logic level_next;
  always_comb
  begin
    level_next = level_reg;
    case (operating_mode_sel)
      PTM_MODE_COMPARE:
      begin
        if (on_rise)
          level_next = output_initial_level;
        else if (match_a)
        begin
          case (pin_function_sel)
            2'b01:   level_next = 1'b0;
            2'b10:   level_next = 1'b1;
            2'b11:   level_next = !level_reg;
            default: level_next = level_reg;
          endcase
        end
      end
      PTM_MODE_PWM:
      begin
        case (pin_function_sel)
          2'b00:   level_next = !output_initial_level;
          2'b01:   level_next = output_initial_level;
          2'b10:   level_next = ((count_reg < duty_reg) || duty_full) ?
                                output_initial_level : !output_initial_level;
          default: level_next = (counter_on && !(match_a && is_pulse)) ?
                                output_initial_level : !output_initial_level;
        endcase
      end
      default: level_next = level_reg;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      level_reg <= 1'b0;
    else
      level_reg <= level_next;
  end

  wire logic drives = operating_mode_sel == PTM_MODE_COMPARE ||
                      operating_mode_sel == PTM_MODE_PWM;
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      timer_output_pin <= 1'b0;
      timer_output_en  <= 1'b0;
    end
    else
    begin
      timer_output_pin <= drives && (level_next ^ output_invert);
      timer_output_en  <= drives;
    end
  end

  // read decode
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    err_next   = 1'b0;
    case (paddr)
      `PTM_OFS_CTRL0:     rdata_next[7:0] = ctrl0_reg;
      `PTM_OFS_CTRL1:     rdata_next[7:0] = ctrl1_reg;
      `PTM_OFS_DUTY_LO:   rdata_next[7:0] = duty_reg[7:0];
      `PTM_OFS_DUTY_HI:   rdata_next[7:0] = hi_byte(duty_reg);
      `PTM_OFS_PERIOD_LO: rdata_next[7:0] = period_reg[7:0];
      `PTM_OFS_PERIOD_HI: rdata_next[7:0] = hi_byte(period_reg);
      `PTM_OFS_COUNT_LO:  rdata_next[7:0] = count_reg[7:0];
      `PTM_OFS_COUNT_HI:  rdata_next[7:0] = hi_byte(count_reg);
      `PTM_OFS_STATUS:    rdata_next[1:0] = {flag_p_reg, flag_a_reg};
      default:            err_next = 1'b1;
    endcase
  end

  // zero-wait slave: answer prepared in the setup cycle
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= apb_setup;
      pslverr <= apb_setup && err_next;
      prdata  <= (apb_setup && !pwrite) ? rdata_next : 32'h0000_0000;
    end
  end

  a_pause_holds: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $past(count_pause) && !$past(on_rise) |-> $stable(count_reg))
    else $error("count moved while paused");
  a_off_holds: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !$past(counter_on) |-> $stable(count_reg))
    else $error("count moved while off");
  a_on_clears: assert property (@(posedge ref_clk) disable iff (!rst_n)
    on_rise |=> count_reg == '0)
    else $error("count not cleared on start");
  a_init_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
    on_rise && operating_mode_sel == PTM_MODE_COMPARE |=>
      timer_output_pin == (output_initial_level ^ output_invert))
    else $error("initial level not restored");
  a_timer_undriven: assert property (@(posedge ref_clk) disable iff (!rst_n)
    operating_mode_sel == PTM_MODE_TIMER |=> !timer_output_en)
    else $error("pin driven in timer mode");
  a_toggle_match: assert property (@(posedge ref_clk) disable iff (!rst_n)
    match_a && !on_rise && operating_mode_sel == PTM_MODE_COMPARE &&
    pin_function_sel == 2'b11 && $stable(output_invert) |=>
      timer_output_pin != $past(timer_output_pin))
    else $error("toggle missing on match");
  a_flag_p_block: assert property (@(posedge ref_clk) disable iff (!rst_n)
    match_p && is_cmp && clear_source_sel && !flag_p_reg |=> !flag_p_reg)
    else $error("p flag raised under a-clear");
  a_flag_a_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
    match_a |=> flag_a_reg)
    else $error("a flag not set on match");
  a_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    match_a && is_cmp && clear_source_sel |=> count_reg == '0)
    else $error("a match did not clear count");
  a_count_up: assert property (@(posedge ref_clk) disable iff (!rst_n)
    run_tick && !clear_now |=> count_reg == $past(count_reg) + CNT_ONE)
    else $error("count did not step");
  a_hi_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    apb_setup && !pwrite && paddr == `PTM_OFS_DUTY_HI |=>
      prdata[31:WIDTH-8] == '0)
    else $error("unimplemented bits read nonzero");
  a_ext_tick: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rise[0] |-> $past(external_clock_pin, 2) && !$past(external_clock_pin, 3))
    else $error("clock pin edge not seen through synchroniser");
endmodule
